// File: shared/tmr_pkg.sv
// Constants shared by the timer and watchdog unit.
package tmr_pkg;
    // ==========================================================
    // Register byte offsets on the peripheral bus.
    localparam logic [13:0] T0_CTRL_OFS    = 14'h0000;
    localparam logic [13:0] T0_TMO_OFS     = 14'h0004;
    localparam logic [13:0] T0_CNT_OFS     = 14'h0008;
    localparam logic [13:0] T1_CTRL_OFS    = 14'h000c;
    localparam logic [13:0] T1_TMO_OFS     = 14'h0010;
    localparam logic [13:0] T1_CNT_OFS     = 14'h0014;
    localparam logic [13:0] T2_CTRL_OFS    = 14'h0018;
    localparam logic [13:0] T2_TMO_OFS     = 14'h001c;
    localparam logic [13:0] T2_CNT_OFS     = 14'h0020;
    localparam logic [13:0] T3_CTRL_OFS    = 14'h0024;
    localparam logic [13:0] T3_TMO_OFS     = 14'h0028;
    localparam logic [13:0] T3_CNT_OFS     = 14'h002c;
    localparam logic [13:0] WD_CTRL_OFS    = 14'h0030;
    localparam logic [13:0] WD_TMO_OFS     = 14'h0034;
    localparam logic [13:0] WD_THR_OFS     = 14'h0038;
    localparam logic [13:0] WD_CNT_OFS     = 14'h003c;
    localparam logic [13:0] WD_STAT_OFS    = 14'h3fcc;
    localparam logic [13:0] WD_STAT_CLR    = 14'h3fd0;
    localparam logic [13:0] WD_STAT_SET    = 14'h3fd4;
    localparam logic [13:0] EN_CLR_OFS     = 14'h3fd8;
    localparam logic [13:0] EN_SET_OFS     = 14'h3fdc;
    localparam logic [13:0] STAT_OFS       = 14'h3fe0;
    localparam logic [13:0] EN_OFS         = 14'h3fe4;
    localparam logic [13:0] STAT_CLR_OFS   = 14'h3fe8;
    localparam logic [13:0] STAT_SET_OFS   = 14'h3fec;
    // ==========================================================
    // Field positions and widths.
    localparam int MODE_BIT      = 0;
    localparam int CASCADE_BIT   = 1;
    localparam int KICK_BIT      = 0;
    localparam int RST_EN_BIT    = 1;
    localparam int LOW_W         = 12;
    localparam int HIGH_W        = 32;
    localparam int WD_W          = 10;
    // ==========================================================
    // Reset values and prescaler counts.
    localparam logic [31:0] REG_RESET     = 32'h0000_0000;
    localparam logic [6:0]  WD_PRESC_LAST = 7'h007f;
endpackage

// File: hw/count_timer.sv
// Down-counting timer with single-shot and free-running modes.
`timescale 1ns/1ps
`default_nettype none
module count_timer
    import tmr_pkg::*;
#(
    parameter int W = LOW_W
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic         tick,
    input  wire logic [W-1:0] timeout,
    input  wire logic         mode,
    input  wire logic         restart,
    output logic [W-1:0]      count,
    output logic              expire
);
    logic running;
    logic load;

    // ==========================================================
    // Counter. A zero timeout parks the counter, so no tick can time out.
    // A restart is taken one cycle late, once the timeout register holds
    // the newly written value rather than the old one.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count   <= W'(0);
            running <= 1'b0;
            expire  <= 1'b0;
            load    <= 1'b0;
        end else begin
            expire <= 1'b0;
            load   <= restart;
            if (timeout == W'(0)) begin
                count   <= W'(0); // RULE10
                running <= 1'b0;
            end else if (load) begin
                count   <= timeout;
                running <= 1'b1;
            end else if (tick && running) begin
                if (count <= W'(1)) begin
                    expire <= 1'b1; // RULE22
                    if (mode) begin
                        count <= timeout;
                    end else begin
                        count   <= W'(0);
                        running <= 1'b0;
                    end
                end else begin
                    count <= count - W'(1);
                end
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // A single-shot run ends with the counter at rest.
    single_stop_a: assert property ( // RULE22
        (expire && !mode && !$past(restart)) |-> (count == W'(0) && !running))
        else $error("single-shot timer did not stop");
endmodule
`default_nettype wire

// File: hw/timers_watchdog.sv
// Timer and watchdog unit behind a 32-bit peripheral slave bus.
// Operation
// [RULE1] Two 12-bit timers on the slow clock.
// [RULE2] Two 32-bit timers on the fast clock.
// [RULE3] One timeout register per timer, no capture.
// [RULE4] All four timer interrupts share one line.
// [RULE5] Timers 0 and 1 can be chained.
// [RULE6] Slow timers: bit 0 selects single-shot or free-running.
// [RULE7] Fast timers have the same two modes.
// [RULE8] Each timer interrupt masks individually.
// [RULE9] Timer 0 timeout in bits 11:0, rest zero.
// [RULE10] Zero timeout disables the timer.
// [RULE11] Timer 0 count readable in bits 11:0.
// [RULE12] Watchdog uses a 10-bit counter.
// [RULE13] Watchdog interrupt goes to the non-maskable input.
// [RULE14] Unfed watchdog expiry requests a chip reset.
// [RULE15] Watchdog reset enable cannot be cleared by software.
// [RULE16] Firmware must kick the watchdog before expiry.
// [RULE17] Enable and status change only via set/clear.
// [RULE18] Chained timer 1 steps on timer 0 terminal count.
// [RULE19] Kick with 1 reloads watchdog; 0 does nothing.
// [RULE20] Watchdog interrupt when count reaches threshold.
// [RULE21] Registers reached over a 32-bit peripheral bus.
// [RULE22] Terminal count: free-running reloads, single-shot stops.
// [RULE23] Set/clear registers act only on written ones.
`timescale 1ns/1ps
`default_nettype none
module timers_watchdog
    import tmr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        low_freq_osc_clock,
    input  wire logic        high_freq_osc_clock,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             timer_irq,
    output logic             watchdog_nmi,
    output logic             reset_controller_req
);
    logic              lfo_q;
    logic              hfo_q;
    logic              lfo_rise;
    logic              hfo_rise;
    logic [6:0]        presc;
    logic              low_tick;
    logic              wd_tick;
    logic              setup;
    logic              wr;
    logic [3:0]        mode;
    logic              cascade_enable;
    logic [LOW_W-1:0]  low_timer_a_initial_count;
    logic [LOW_W-1:0]  tmo1;
    logic [HIGH_W-1:0] tmo2;
    logic [HIGH_W-1:0] tmo3;
    logic [LOW_W-1:0]  low_timer_a_current_value;
    logic [LOW_W-1:0]  cnt1;
    logic [HIGH_W-1:0] cnt2;
    logic [HIGH_W-1:0] cnt3;
    logic [3:0]        expire;
    logic [3:0]        restart;
    logic              t1_tick;
    logic [3:0]        irq_status;
    logic [3:0]        irq_enable;
    logic [3:0]        next_irq_status;
    logic [3:0]        next_irq_enable;
    logic [WD_W-1:0]   wd_timeout;
    logic [WD_W-1:0]   wd_threshold;
    logic [WD_W-1:0]   wd_count;
    logic              wd_run;
    logic              wd_rst_en;
    logic              wd_status;
    logic              next_wd_status;
    logic              wd_kick;
    logic              wd_step;
    logic              wd_hit;
    logic              wd_expire;
    logic [31:0]       rd_val;
    logic              mapped;

    // Write to a given offset during the setup phase.
    function automatic logic wr_at(input logic [13:0] ofs);
        return wr && (paddr == ofs);
    endfunction

    // ==========================================================
    // Oscillator edges. Both inputs are synchronous, so a single stage
    // is enough to find the rising edge.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lfo_q <= 1'b0;
            hfo_q <= 1'b0;
            presc <= 7'h00;
        end else begin
            lfo_q <= low_freq_osc_clock;
            hfo_q <= high_freq_osc_clock;
            if (lfo_rise) begin
                presc <= presc + 7'h01;
            end
        end
    end

    assign lfo_rise = low_freq_osc_clock && !lfo_q;
    assign hfo_rise = high_freq_osc_clock && !hfo_q;
    // Slow timers step at half the slow clock, the watchdog at 1/128.
    assign low_tick = lfo_rise && presc[0];
    assign wd_tick  = lfo_rise && (presc == WD_PRESC_LAST);

    // ==========================================================
    // Bus decode. Every access is taken in the setup phase and
    // answered in the access phase with no wait state.
    assign setup = psel && !penable; // RULE21
    assign wr    = setup && pwrite;

    // Configuration registers.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mode                      <= 4'h0;
            cascade_enable            <= 1'b0;
            low_timer_a_initial_count <= REG_RESET[LOW_W-1:0];
            tmo1                      <= REG_RESET[LOW_W-1:0];
            tmo2                      <= REG_RESET;
            tmo3                      <= REG_RESET;
            wd_timeout                <= REG_RESET[WD_W-1:0];
            wd_threshold              <= REG_RESET[WD_W-1:0];
        end else begin
            if (wr_at(T0_CTRL_OFS)) begin
                mode[0] <= pwdata[MODE_BIT]; // RULE6
            end
            if (wr_at(T1_CTRL_OFS)) begin
                mode[1]        <= pwdata[MODE_BIT];
                cascade_enable <= pwdata[CASCADE_BIT]; // RULE5
            end
            if (wr_at(T2_CTRL_OFS)) begin
                mode[2] <= pwdata[MODE_BIT]; // RULE7
            end
            if (wr_at(T3_CTRL_OFS)) begin
                mode[3] <= pwdata[MODE_BIT];
            end
            if (wr_at(T0_TMO_OFS)) begin
                low_timer_a_initial_count <= pwdata[LOW_W-1:0]; // RULE9
            end
            if (wr_at(T1_TMO_OFS)) begin
                tmo1 <= pwdata[LOW_W-1:0];
            end
            if (wr_at(T2_TMO_OFS)) begin
                tmo2 <= pwdata;
            end
            if (wr_at(T3_TMO_OFS)) begin
                tmo3 <= pwdata;
            end
            if (wr_at(WD_TMO_OFS)) begin
                wd_timeout <= pwdata[WD_W-1:0];
            end
            if (wr_at(WD_THR_OFS)) begin
                wd_threshold <= pwdata[WD_W-1:0];
            end
        end
    end

    // ==========================================================
    // Timers. Writing a timeout starts that timer from the new value.
    assign restart = {wr && (paddr == T3_TMO_OFS), wr && (paddr == T2_TMO_OFS),
                      wr && (paddr == T1_TMO_OFS), wr && (paddr == T0_TMO_OFS)};
    // Chained, timer 1 only steps when timer 0 wraps.
    assign t1_tick = cascade_enable ? expire[0] : low_tick; // RULE18

    count_timer #(.W(LOW_W)) u_t0 ( // RULE1
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (low_tick),
        .timeout (low_timer_a_initial_count),
        .mode    (mode[0]),
        .restart (restart[0]),
        .count   (low_timer_a_current_value),
        .expire  (expire[0])
    );

    count_timer #(.W(LOW_W)) u_t1 (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (t1_tick),
        .timeout (tmo1),
        .mode    (mode[1]),
        .restart (restart[1]),
        .count   (cnt1),
        .expire  (expire[1])
    );

    count_timer #(.W(HIGH_W)) u_t2 ( // RULE2
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (hfo_rise),
        .timeout (tmo2),
        .mode    (mode[2]),
        .restart (restart[2]),
        .count   (cnt2),
        .expire  (expire[2])
    );

    count_timer #(.W(HIGH_W)) u_t3 ( // RULE3
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick    (hfo_rise),
        .timeout (tmo3),
        .mode    (mode[3]),
        .restart (restart[3]),
        .count   (cnt3),
        .expire  (expire[3])
    );

    // ==========================================================
    // Interrupt state. Hardware events win over a same-cycle clear,
    // so a timeout landing on the clear write is never lost.
    always_comb begin
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        next_wd_status  = wd_status;
        if (wr_at(STAT_CLR_OFS)) begin
            next_irq_status = next_irq_status & ~pwdata[3:0]; // RULE23
        end
        if (wr_at(STAT_SET_OFS)) begin
            next_irq_status = next_irq_status | pwdata[3:0]; // RULE17
        end
        next_irq_status = next_irq_status | expire;
        if (wr_at(EN_CLR_OFS)) begin
            next_irq_enable = next_irq_enable & ~pwdata[3:0];
        end
        if (wr_at(EN_SET_OFS)) begin
            next_irq_enable = next_irq_enable | pwdata[3:0];
        end
        if (wr_at(WD_STAT_CLR) && pwdata[0]) begin
            next_wd_status = 1'b0;
        end
        if ((wr_at(WD_STAT_SET) && pwdata[0]) || wd_hit) begin
            next_wd_status = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status   <= 4'h0;
            irq_enable   <= 4'h0;
            wd_status    <= 1'b0;
            timer_irq    <= 1'b0;
            watchdog_nmi <= 1'b0;
        end else begin
            irq_status   <= next_irq_status;
            irq_enable   <= next_irq_enable;
            wd_status    <= next_wd_status;
            timer_irq    <= |(next_irq_status & next_irq_enable); // RULE4
            watchdog_nmi <= next_wd_status; // RULE13
        end
    end

    // ==========================================================
    // Watchdog. A kick with bit 0 set reloads and arms the counter.
    assign wd_kick   = wr && (paddr == WD_CTRL_OFS) && pwdata[KICK_BIT]; // RULE19
    assign wd_step   = wd_tick && wd_run && (wd_timeout != 10'h000) && !wd_kick;
    assign wd_hit    = wd_step && ((wd_count - 10'h001) == wd_threshold); // RULE20
    assign wd_expire = wd_step && (wd_count <= 10'h001);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wd_count <= REG_RESET[WD_W-1:0];
            wd_run   <= 1'b0;
        end else if (wd_timeout == 10'h000) begin
            wd_count <= 10'h000;
            wd_run   <= 1'b0;
        end else if (wd_kick) begin
            wd_count <= wd_timeout;
            wd_run   <= 1'b1;
        end else if (wd_step) begin
            wd_count <= wd_count - 10'h001; // RULE12
            wd_run   <= !wd_expire;
        end
    end

    // The enable is sticky: a written zero is ignored, only expiry or
    // reset drops it, so a runaway program cannot switch it off.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wd_rst_en            <= 1'b0;
            reset_controller_req <= 1'b0;
        end else begin
            reset_controller_req <= wd_expire && wd_rst_en; // RULE14
            if (wd_expire) begin
                wd_rst_en <= 1'b0; // RULE15
            end else if (wr_at(WD_CTRL_OFS) && pwdata[RST_EN_BIT]) begin
                wd_rst_en <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read mux. Write-only and reserved words read zero; only
    // unaligned offsets answer with an error.
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            T0_CTRL_OFS:  rd_val[0] = mode[0];
            T0_TMO_OFS:   rd_val[LOW_W-1:0] = low_timer_a_initial_count;
            T0_CNT_OFS:   rd_val[LOW_W-1:0] = low_timer_a_current_value; // RULE11
            T1_CTRL_OFS:  rd_val[1:0] = {cascade_enable, mode[1]};
            T1_TMO_OFS:   rd_val[LOW_W-1:0] = tmo1;
            T1_CNT_OFS:   rd_val[LOW_W-1:0] = cnt1;
            T2_CTRL_OFS:  rd_val[0] = mode[2];
            T2_TMO_OFS:   rd_val = tmo2;
            T2_CNT_OFS:   rd_val = cnt2;
            T3_CTRL_OFS:  rd_val[0] = mode[3];
            T3_TMO_OFS:   rd_val = tmo3;
            T3_CNT_OFS:   rd_val = cnt3;
            WD_CTRL_OFS:  rd_val[RST_EN_BIT] = wd_rst_en;
            WD_TMO_OFS:   rd_val[WD_W-1:0] = wd_timeout;
            WD_THR_OFS:   rd_val[WD_W-1:0] = wd_threshold;
            WD_CNT_OFS:   rd_val[WD_W-1:0] = wd_count;
            WD_STAT_OFS:  rd_val[0] = wd_status;
            STAT_OFS:     rd_val[3:0] = irq_status;
            EN_OFS:       rd_val[3:0] = irq_enable;
            WD_STAT_CLR, WD_STAT_SET, EN_CLR_OFS, EN_SET_OFS,
            STAT_CLR_OFS, STAT_SET_OFS: rd_val = 32'h0000_0000;
            default: begin
                mapped = (paddr[1:0] == 2'b00) && (paddr >= 14'h0040);
            end
        endcase
    end

    // Bus answer, registered so every output comes from a flip-flop.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            prdata  <= (setup && !pwrite && mapped) ? rd_val : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    irq_line_a: assert property ( // RULE4
        timer_irq == |(irq_status & irq_enable))
        else $error("shared timer line disagrees with status and enable");

    status_set_a: assert property ( // RULE22
        (|expire) |=> ((irq_status & $past(expire)) == $past(expire)))
        else $error("timeout did not set its status bit");

    mask_clear_a: assert property ( // RULE8
        (wr_at(EN_CLR_OFS) && !wr_at(EN_SET_OFS))
        |=> (irq_enable == ($past(irq_enable) & ~$past(pwdata[3:0]))))
        else $error("enable clear touched the wrong bits");

    zero_off_a: assert property ( // RULE10
        (low_timer_a_initial_count == 12'h000)
        |=> (low_timer_a_current_value == 12'h000) && !expire[0])
        else $error("timer 0 ran with zero timeout");

    rst_en_sticky_a: assert property ( // RULE15
        (wd_rst_en && !wd_expire) |=> wd_rst_en)
        else $error("watchdog reset enable dropped without expiry");

    kick_reload_a: assert property ( // RULE19
        (wd_kick && wd_timeout != 10'h000) |=> (wd_count == $past(wd_timeout)) && wd_run)
        else $error("kick did not reload watchdog");

    nmi_hit_a: assert property ( // RULE13
        wd_hit |=> watchdog_nmi && wd_status)
        else $error("watchdog threshold did not raise the non-maskable line");

    reset_req_a: assert property ( // RULE14
        (wd_expire && wd_rst_en) |=> reset_controller_req ##1 !reset_controller_req)
        else $error("watchdog expiry did not pulse the reset request");

    cascade_hold_a: assert property ( // RULE18
        (cascade_enable && !expire[0] && !$past(restart[1]) && tmo1 != 12'h000) |=> $stable(cnt1))
        else $error("chained timer 1 moved without timer 0 wrap");
endmodule
`default_nettype wire

// File: verification/osc_model.sv
// Free-running oscillator model feeding the slow and fast count domains.
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    input  wire logic ref_clk,
    output logic      low_freq_osc_clock,
    output logic      high_freq_osc_clock
);
    // ==========================================
    // Oscillator phases
    logic [2:0] phase = 3'h0;

    // Real oscillators never stop, so they keep running through reset too.
    // Edges stay several ref_clk cycles apart, so the synchronous edge detect never misses one.
    always begin
        @(posedge ref_clk);
        #1;
        phase = phase + 3'h1;
    end

    // Both levels start low because the phase starts at zero.
    assign low_freq_osc_clock  = phase[2];
    assign high_freq_osc_clock = phase[1];
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking bench for the timer and watchdog unit.
`timescale 1ns/1ps
`default_nettype none
`define check(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb
    import tmr_pkg::*;
;
    logic        ref_clk = 1'h0;
    logic        nrst = 1'h0;
    logic        low_freq_osc_clock;
    logic        high_freq_osc_clock;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [13:0] paddr = 14'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer_irq;
    logic        watchdog_nmi;
    logic        reset_controller_req;
    int          fail_count = 0;
    int          total_checks = 0;
    logic [31:0] q;
    logic        er;
    int          i;

    timers_watchdog timers_watchdog_i (.ref_clk(ref_clk), .nrst(nrst), .low_freq_osc_clock(low_freq_osc_clock),
        .high_freq_osc_clock(high_freq_osc_clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer_irq(timer_irq), .watchdog_nmi(watchdog_nmi), .reset_controller_req(reset_controller_req));
    osc_model osc_model_i (.ref_clk(ref_clk), .low_freq_osc_clock(low_freq_osc_clock),
        .high_freq_osc_clock(high_freq_osc_clock));

    // ==========================================
    // Clock and bus access
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // One setup and one access phase; the request stays put until pready is seen.
    task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] rq, output logic e);
        int n;
        n = 0;
        @(posedge ref_clk);
        #1;
        psel = 1'h1;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(posedge ref_clk);
        #1;
        penable = 1'h1;
        @(negedge ref_clk);
        while (pready !== 1'h1 && n < 8) begin
            n++;
            @(negedge ref_clk);
        end
        rq = prdata;
        e = pslverr;
        @(posedge ref_clk);
        #1;
        psel = 1'h0;
        penable = 1'h0;
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d);
        logic [31:0] rq;
        logic        e;
        bus(1'h1, a, d, rq, e);
    endtask

    task automatic rd_chk(input string nm, input logic [13:0] a, input logic [31:0] exp);
        logic [31:0] rq;
        logic        e;
        bus(1'h0, a, 32'h0000_0000, rq, e);
        `check(nm, exp, rq)
    endtask

    // Polls timer 0 status, then clears it so the next expiry can be seen.
    task automatic wait_t0;
        logic [31:0] rq;
        logic        e;
        int          n;
        rq = 32'h0000_0000;
        n = 0;
        while (rq[0] !== 1'h1 && n < 60) begin
            bus(1'h0, STAT_OFS, 32'h0000_0000, rq, e);
            n++;
        end
        `check("timer0 expiry", 1'h1, rq[0])
        wr(STAT_CLR_OFS, 32'h0000_0001);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A hang costs a mismatch; the whole sequence needs well under 8000 cycles.
    initial begin
        #(40 * 12000);
        fail_count++;
        print_verdict();
    end

    // ==========================================
    // Test sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        nrst = 1'h1;
        for (i = 0; i < 16; i++) rd_chk("reset value", 14'(i * 4), 32'h0000_0000);
        rd_chk("status reset", STAT_OFS, 32'h0000_0000);
        bus(1'h0, 14'h0002, 32'h0000_0000, q, er);
        `check("unmapped error", 1'h1, er)
        bus(1'h0, 14'h0040, 32'h0000_0000, q, er);
        `check("reserved error", 1'h0, er)
        `check("reserved data", 32'h0000_0000, q)
        // Enable and status only move through their set and clear words.
        wr(EN_SET_OFS, 32'h0000_0005);
        wr(EN_SET_OFS, 32'h0000_0002);
        wr(EN_CLR_OFS, 32'h0000_0001);
        wr(EN_OFS, 32'h0000_ffff);
        rd_chk("irq enable", EN_OFS, 32'h0000_0006);
        wr(STAT_SET_OFS, 32'h0000_0008);
        `check("masked irq", 1'h0, timer_irq)
        wr(STAT_SET_OFS, 32'h0000_0002);
        `check("shared irq", 1'h1, timer_irq)
        rd_chk("irq status", STAT_OFS, 32'h0000_000a);
        wr(STAT_CLR_OFS, 32'h0000_000a);
        `check("irq cleared", 1'h0, timer_irq)
        // Field widths and the zero-timeout disable.
        wr(T0_TMO_OFS, 32'hffff_f000);
        rd_chk("t0 timeout width", T0_TMO_OFS, 32'h0000_0000);
        rd_chk("t0 disabled", T0_CNT_OFS, 32'h0000_0000);
        wr(T2_TMO_OFS, 32'hffff_ffff);
        rd_chk("t2 timeout width", T2_TMO_OFS, 32'hffff_ffff);
        // Chained pair: timer 1 steps once per timer 0 expiry only.
        wr(T1_CTRL_OFS, 32'h0000_0003);
        wr(T1_TMO_OFS, 32'h0000_0005);
        wr(T0_CTRL_OFS, 32'h0000_0001);
        wr(T0_TMO_OFS, 32'h0000_0002);
        wait_t0();
        wait_t0();
        wr(T0_TMO_OFS, 32'h0000_0000);
        rd_chk("cascaded count", T1_CNT_OFS, 32'h0000_0003);
        // Fast timers: single-shot stops, free-running reloads.
        wr(T3_CTRL_OFS, 32'h0000_0001);
        wr(T2_CTRL_OFS, 32'h0000_0000);
        wr(T2_TMO_OFS, 32'h0000_0004);
        wr(T3_TMO_OFS, 32'h0000_0004);
        repeat (60) @(posedge ref_clk);
        rd_chk("t2 stopped", T2_CNT_OFS, 32'h0000_0000);
        rd_chk("t2 t3 status", STAT_OFS, 32'h0000_000c);
        bus(1'h0, T3_CNT_OFS, 32'h0000_0000, q, er);
        `check("t3 reloaded", 1'h1, q != 32'h0000_0000)
        wr(STAT_CLR_OFS, 32'h0000_000f);
        // Watchdog: threshold interrupt, kick, locked reset enable, expiry.
        wr(WD_TMO_OFS, 32'h0000_0003);
        wr(WD_THR_OFS, 32'h0000_0002);
        wr(WD_CTRL_OFS, 32'h0000_0003);
        for (i = 0; i < 1100 && watchdog_nmi !== 1'h1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `check("nmi raised", 1'h1, watchdog_nmi)
        `check("nmi apart", 1'h0, timer_irq)
        rd_chk("wd count", WD_CNT_OFS, 32'h0000_0002);
        wr(WD_CTRL_OFS, 32'h0000_0001);
        rd_chk("wd reload", WD_CNT_OFS, 32'h0000_0003);
        wr(WD_CTRL_OFS, 32'h0000_0000);
        rd_chk("wd no effect", WD_CNT_OFS, 32'h0000_0003);
        rd_chk("reset enable held", WD_CTRL_OFS, 32'h0000_0002);
        for (i = 0; i < 3500 && reset_controller_req !== 1'h1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        `check("reset request", 1'h1, reset_controller_req)
        rd_chk("enable dropped", WD_CTRL_OFS, 32'h0000_0000);
        rd_chk("wd stopped", WD_CNT_OFS, 32'h0000_0000);
        wr(WD_STAT_CLR, 32'h0000_0001);
        `check("nmi cleared", 1'h0, watchdog_nmi)
        wr(WD_STAT_SET, 32'h0000_0001);
        rd_chk("wd status set", WD_STAT_OFS, 32'h0000_0001);
        print_verdict();
    end
endmodule
`default_nettype wire
